// >>> hw/dpg_defines.svh
// constants for the dual-port gpio block, with the overview list
// Overview of operation
// - port A pin drives when its direction bit is 1, else floats as input
// - reset clears all eight port A direction bits
// - port A data read gives latch where output, synced pin where input
// - data writes always update the latch, whatever the direction bit
// - eight port B data latches at 0x0001, untouched by reset
// - port B pin drives when its direction bit is 1, else input
// - reset clears all eight port B direction bits
// - port B data read gives latch where output, pin where input
// - serial enable hands port B pins 0 and 1 to transmit and receive
// - timer one select bits take port B pins 2 and 3 from the port
// - timer two select bits take port B pins 4 and 5 from the port
// - converter channel select may claim port B pin 6 or 7 as analog
// - converter pins not selected stay ordinary digital port pins
// - led enable bits give pins 0 to 5 high-sink drive when output, but none on timer-owned pins
// - with serial enabled, led bit 0 gives the transmit pin high sink
// - port A data latches at 0x0000, software read/write, kept over reset
// - keypad enable bits take port A pins 0 to 3 from the port
`ifndef DPG_DEFINES_SVH
`define DPG_DEFINES_SVH
`define DPG_IDX_DATA_A    10'h000
`define DPG_IDX_DATA_B    10'h001
`define DPG_IDX_DIRA      10'h004
`define DPG_IDX_DIRB      10'h005
`define DPG_IDX_LED       10'h00C
`define DPG_ADDR_DATA_A   {`DPG_IDX_DATA_A, 2'h0}
`define DPG_ADDR_DATA_B   {`DPG_IDX_DATA_B, 2'h0}
`define DPG_ADDR_DIRA     {`DPG_IDX_DIRA, 2'h0}
`define DPG_ADDR_DIRB     {`DPG_IDX_DIRB, 2'h0}
`define DPG_ADDR_LED      {`DPG_IDX_LED, 2'h0}
`define DPG_ADDR_INFO     12'h040
`define DPG_DIR_RESET     8'h00
`define DPG_LED_RESET     8'h00
`define DPG_LED_MASK      8'h3F
`define DPG_CONV_PIN6     5'h0A
`define DPG_CONV_PIN7     5'h0B
`define DPG_ELS_PORT      2'h0
`define DPG_BIT_TXD       0
`define DPG_BIT_RXD       1
`define DPG_ADDR_MSB      11
`endif

// >>> hw/dpg_gpio.sv
// dual-port gpio with peripheral overrides and led drive, apb slave
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "dpg_defines.svh"
module dpg_gpio (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // peripheral selects
  input  wire dpg_pkg::dpg_periph_sel_type periph_sel,
  // peripheral signals sharing the pins
  input  wire logic                        serial_tx,
  input  wire logic [3:0]                  timer_out,
  input  wire logic [3:0]                  timer_out_en,
  output logic                             serial_rx,
  output logic [3:0]                       timer_in,
  output logic [3:0]                       keypad_in,
  // pins
  input  wire logic [7:0]                  port_a_in,
  input  wire logic [7:0]                  port_b_in,
  output dpg_pkg::dpg_pin_drive_type       port_a_pin,
  output dpg_pkg::dpg_pin_drive_type       port_b_pin,
  output logic [7:0]                       port_a_analog,
  output logic [7:0]                       port_b_analog,
  output logic [7:0]                       port_b_high_sink
);
  logic [7:0]                 port_a_data_latch_q;
  logic [7:0]                 port_a_data_latch_d;
  logic [7:0]                 port_b_data_latch_q;
  logic [7:0]                 port_b_data_latch_d;
  logic [7:0]                 port_a_direction_q;
  logic [7:0]                 port_a_direction_d;
  logic [7:0]                 port_b_direction_q;
  logic [7:0]                 port_b_direction_d;
  logic [7:0]                 port_b_led_drive_enable_q;
  logic [7:0]                 port_b_led_drive_enable_d;
  logic [31:0]                prdata_q;
  logic [31:0]                prdata_d;
  logic                       pready_q;
  logic                       pready_d;
  logic                       pslverr_q;
  logic                       pslverr_d;
  dpg_pkg::dpg_pin_drive_type pa_q;
  dpg_pkg::dpg_pin_drive_type pa_d;
  dpg_pkg::dpg_pin_drive_type pb_q;
  dpg_pkg::dpg_pin_drive_type pb_d;
  logic [7:0]                 pa_an_q;
  logic [7:0]                 pa_an_d;
  logic [7:0]                 pb_an_q;
  logic [7:0]                 pb_an_d;
  logic [7:0]                 hs_q;
  logic [7:0]                 hs_d;
  logic                       rx_q;
  logic                       rx_d;
  logic [3:0]                 tin_q;
  logic [3:0]                 tin_d;
  logic [3:0]                 kin_q;
  logic [3:0]                 kin_d;
  logic [15:0]                pin_sync;
  logic [7:0]                 sync_a;
  logic [7:0]                 sync_b;
  logic                       wr_access;
  logic                       wr_commit;
  logic                       rd_access;
  logic                       addr_hit;
  logic [7:0]                 b_alt;
  logic [7:0]                 a_alt;

  // mixed read of a port: latch on outputs, pin on inputs
  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
    port_read = (dir & latch) | (~dir & pin);
  endfunction

  // merge the low byte of a write under its lane strobe
  function automatic logic [7:0] byte_write(input logic [7:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
    byte_write = st[0] ? wd[7:0] : old;
  endfunction

  // pin levels synchronised before any read
  dpg_pin_sync #(.WIDTH(16)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({port_b_in, port_a_in}),
    .sync_out (pin_sync)
  );
  assign sync_a = pin_sync[7:0];
  assign sync_b = pin_sync[15:8];

  // one-wait apb access: ready is raised in the second access cycle
  assign wr_access = psel && penable && pwrite && !pready_q;
  assign rd_access = psel && penable && !pwrite && !pready_q;
  // a write commits at the edge that samples ready high
  assign wr_commit = psel && penable && pwrite && pready_q;
  always_comb
  begin
    case (paddr)
      `DPG_ADDR_DATA_A, `DPG_ADDR_DATA_B, `DPG_ADDR_DIRA,
      `DPG_ADDR_DIRB, `DPG_ADDR_LED: addr_hit = 1'h1;
      default: addr_hit = 1'h0;
    endcase
  end

  // register file next values
  always_comb
  begin
    port_a_data_latch_d       = port_a_data_latch_q;
    port_b_data_latch_d       = port_b_data_latch_q;
    port_a_direction_d        = port_a_direction_q;
    port_b_direction_d        = port_b_direction_q;
    port_b_led_drive_enable_d = port_b_led_drive_enable_q;
    if (wr_commit)
    begin
      case (paddr)
        `DPG_ADDR_DATA_A: port_a_data_latch_d =
          byte_write(port_a_data_latch_q, pwdata, pstrb);
        `DPG_ADDR_DATA_B: port_b_data_latch_d =
          byte_write(port_b_data_latch_q, pwdata, pstrb);
        `DPG_ADDR_DIRA: port_a_direction_d =
          byte_write(port_a_direction_q, pwdata, pstrb);
        `DPG_ADDR_DIRB: port_b_direction_d =
          byte_write(port_b_direction_q, pwdata, pstrb);
        `DPG_ADDR_LED: port_b_led_drive_enable_d =
          byte_write(port_b_led_drive_enable_q, pwdata, pstrb)
          & `DPG_LED_MASK;
        default: ;
      endcase
    end
  end

  // data latches keep their value over reset
  always_ff @(posedge pclk)
  begin
    port_a_data_latch_q <= port_a_data_latch_d;
    port_b_data_latch_q <= port_b_data_latch_d;
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_a_direction_q        <= `DPG_DIR_RESET;
      port_b_direction_q        <= `DPG_DIR_RESET;
      port_b_led_drive_enable_q <= `DPG_LED_RESET;
    end
    else
    begin
      port_a_direction_q        <= port_a_direction_d;
      port_b_direction_q        <= port_b_direction_d;
      port_b_led_drive_enable_q <= port_b_led_drive_enable_d;
    end
  end

  // apb answer next values
  always_comb
  begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = 1'h0;
    prdata_d  = '0;
    if (rd_access)
    begin
      case (paddr)
        `DPG_ADDR_DATA_A: prdata_d[7:0] =
          port_read(port_a_direction_q, port_a_data_latch_q, sync_a);
        `DPG_ADDR_DATA_B: prdata_d[7:0] =
          port_read(port_b_direction_q, port_b_data_latch_q, sync_b);
        `DPG_ADDR_DIRA: prdata_d[7:0] = port_a_direction_q;
        `DPG_ADDR_DIRB: prdata_d[7:0] = port_b_direction_q;
        `DPG_ADDR_LED: prdata_d[7:0] = port_b_led_drive_enable_q;
        default: prdata_d = '0;
      endcase
    end
    if ((rd_access || wr_access) && !addr_hit)
      pslverr_d = 1'h1;
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= '0;
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // pin ownership for each port pin
  always_comb
  begin
    a_alt = {4'h0, periph_sel.keypad_irq_pin_enable};
    b_alt = 8'h00;
    b_alt[`DPG_BIT_TXD] = periph_sel.serial_if_enable;
    b_alt[`DPG_BIT_RXD] = periph_sel.serial_if_enable;
    b_alt[2] = periph_sel.timer_one_els0 != `DPG_ELS_PORT;
    b_alt[3] = periph_sel.timer_one_els1 != `DPG_ELS_PORT;
    b_alt[4] = periph_sel.timer_two_els0 != `DPG_ELS_PORT;
    b_alt[5] = periph_sel.timer_two_els1 != `DPG_ELS_PORT;
    b_alt[6] = periph_sel.converter_channel_select ==
      `DPG_CONV_PIN6;
    b_alt[7] = periph_sel.converter_channel_select ==
      `DPG_CONV_PIN7;
  end

  // port A drive next values
  always_comb
  begin
    pa_d.out = port_a_data_latch_q;
    pa_d.oe  = port_a_direction_q & ~a_alt;
    pa_an_d  = 8'h00;
    kin_d    = sync_a[3:0] & a_alt[3:0];
  end

  // port A drive registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_q    <= '0;
      pa_an_q <= 8'h00;
      kin_q   <= 4'h0;
    end
    else
    begin
      pa_q    <= pa_d;
      pa_an_q <= pa_an_d;
      kin_q   <= kin_d;
    end
  end

  // port B drive next values
  always_comb
  begin
    pb_d.out = port_b_data_latch_q;
    pb_d.oe  = port_b_direction_q & ~b_alt;
    pb_d.out[`DPG_BIT_TXD] = b_alt[`DPG_BIT_TXD] ?
      serial_tx : port_b_data_latch_q[`DPG_BIT_TXD];
    pb_d.oe[`DPG_BIT_TXD] = b_alt[`DPG_BIT_TXD] ? 1'h1 :
      port_b_direction_q[`DPG_BIT_TXD];
    for (int i = 0; i < 4; i++)
    begin
      if (b_alt[i+2])
      begin
        pb_d.out[i+2] = timer_out[i];
        pb_d.oe[i+2]  = timer_out_en[i];
      end
    end
    pb_an_d = b_alt & 8'hC0;
    hs_d = port_b_led_drive_enable_q & pb_d.oe & ~b_alt;
    hs_d[`DPG_BIT_TXD] = port_b_led_drive_enable_q[`DPG_BIT_TXD] &
      pb_d.oe[`DPG_BIT_TXD];
    rx_d  = b_alt[`DPG_BIT_RXD] & sync_b[`DPG_BIT_RXD];
    tin_d = sync_b[5:2] & b_alt[5:2];
  end

  // port B drive registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb_q    <= '0;
      pb_an_q <= 8'h00;
      hs_q    <= 8'h00;
      rx_q    <= 1'h0;
      tin_q   <= 4'h0;
    end
    else
    begin
      pb_q    <= pb_d;
      pb_an_q <= pb_an_d;
      hs_q    <= hs_d;
      rx_q    <= rx_d;
      tin_q   <= tin_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign port_a_pin       = pa_q;
  assign port_b_pin       = pb_q;
  assign port_a_analog    = pa_an_q;
  assign port_b_analog    = pb_an_q;
  assign port_b_high_sink = hs_q;
  assign serial_rx        = rx_q;
  assign timer_in         = tin_q;
  assign keypad_in        = kin_q;
endmodule

// >>> hw/dpg_pin_sync.sv
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module dpg_pin_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // next values of both stages
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // register both stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> hw/dpg_pkg.sv
// types shared by the dual-port gpio block
package dpg_pkg;
  // pin bundle for one eight-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dpg_pin_drive_type;
  // alternate-function selects from the on-chip peripherals
  typedef struct packed {
    logic       serial_if_enable;
    logic [1:0] timer_one_els0;
    logic [1:0] timer_one_els1;
    logic [1:0] timer_two_els0;
    logic [1:0] timer_two_els1;
    logic [4:0] converter_channel_select;
    logic [3:0] keypad_irq_pin_enable;
  } dpg_periph_sel_type;
endpackage

// >>> test/dpg_gpio_properties.sv
// port-level assertions for the dual-port gpio block
`timescale 1ns/1ps
`include "dpg_defines.svh"
module dpg_gpio_properties (
  // clock and reset
  input logic                        pclk,
  input logic                        presetn,
  // apb slave side
  input logic                        psel,
  input logic                        penable,
  input logic [31:0]                 prdata,
  input logic                        pready,
  input logic                        pslverr,
  // selects and pins
  input dpg_pkg::dpg_periph_sel_type periph_sel,
  input logic                        serial_tx,
  input dpg_pkg::dpg_pin_drive_type  port_a_pin,
  input dpg_pkg::dpg_pin_drive_type  port_b_pin,
  input logic [7:0]                  port_b_analog,
  input logic [7:0]                  port_b_high_sink
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus answer timing
  property p_answer;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bad answer");
  property p_idle;
    !(psel && penable) |=> !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_rdata;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("rdata idle");
  property p_upper;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("lone slverr");
  // pins start as inputs
  property p_boot;
    $rose(presetn) |-> port_a_pin.oe == 8'h00 && port_b_pin.oe == 8'h00;
  endproperty
  a_boot: assert property (p_boot) else $error("boot oe");
  // peripheral overrides
  property p_serial;
    periph_sel.serial_if_enable [*2] |->
      port_b_pin.oe[0] && port_b_pin.out[0] == $past(serial_tx);
  endproperty
  a_serial: assert property (p_serial) else $error("tx pin");
  property p_analog;
    (periph_sel.converter_channel_select == `DPG_CONV_PIN7) [*2] |->
      port_b_analog[7] && !port_b_analog[6] && !port_b_pin.oe[7];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin");
  property p_keypad;
    (port_a_pin.oe[3:0] & $past(periph_sel.keypad_irq_pin_enable)) == 4'h0;
  endproperty
  a_keypad: assert property (p_keypad) else $error("keypad oe");
  property p_sink;
    port_b_high_sink[7:6] == 2'h0 &&
      (port_b_high_sink & ~port_b_pin.oe) == 8'h00;
  endproperty
  a_sink: assert property (p_sink) else $error("sink drive");
endmodule

bind dpg_gpio dpg_gpio_properties dpg_gpio_properties_inst (.*);

// >>> test/dpg_pin_world.sv
// board model: driven pins follow the port, others the board level
`timescale 1ns/1ps
module dpg_pin_world (
  // drive from the port
  input dpg_pkg::dpg_pin_drive_type port_a_pin,
  input dpg_pkg::dpg_pin_drive_type port_b_pin,
  // board levels on undriven pins
  input logic [7:0]                 ext_a,
  input logic [7:0]                 ext_b,
  // pin levels back to the port
  output logic [7:0]                port_a_in,
  output logic [7:0]                port_b_in
);
  // enabled buffer wins over the board
  assign port_a_in = (port_a_pin.out & port_a_pin.oe)
                   | (ext_a & ~port_a_pin.oe);
  assign port_b_in = (port_b_pin.out & port_b_pin.oe)
                   | (ext_b & ~port_b_pin.oe);
endmodule

// >>> test/testbench.sv
// self-checking bench for the dual-port gpio block
`timescale 1ns/1ps
`include "dpg_defines.svh"
module testbench;
  logic                        pclk, presetn, psel, penable, pwrite;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata, rd;
  logic                        pready, pslverr, er, serial_tx, serial_rx;
  logic [3:0]                  timer_out, timer_out_en, timer_in;
  logic [3:0]                  keypad_in;
  logic [7:0]                  port_a_in, port_b_in, ext_a, ext_b;
  logic [7:0]                  port_a_analog, port_b_analog;
  logic [7:0]                  port_b_high_sink;
  dpg_pkg::dpg_periph_sel_type periph_sel;
  dpg_pkg::dpg_pin_drive_type  port_a_pin, port_b_pin;
  int                          err_total, cmp_count;

  dpg_gpio dpg_gpio_inst (.pstrb(4'hF), .*);
  dpg_pin_world dpg_pin_world_inst (.*);

  // free-running clock
  always #4 pclk = ~pclk;

  // one apb transfer, then an idle edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 50);
    if (pready !== 1'h1)
    begin
      $display("mismatch pready expected 1 seen %b", pready);
      err_total++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // compare and count
  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask

  // read and compare
  task automatic rdc(input string s, input logic [11:0] a,
                     input logic [31:0] e);
    apb(1'h0, a, 8'h00);
    chk(s, e, rd);
  endtask

  // let pins pass the synchroniser
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask

  // reset values, led mask, unmapped place
  task automatic t_regs;
    rdc("dir_a", `DPG_ADDR_DIRA, 32'h0);
    rdc("dir_b", `DPG_ADDR_DIRB, 32'h0);
    rdc("led", `DPG_ADDR_LED, 32'h0);
    apb(1'h1, `DPG_ADDR_LED, 8'hFF);
    rdc("led_rw", `DPG_ADDR_LED, 32'h3F);
    rdc("unmapped", 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
  endtask

  // latch write as input, then mixed direction
  task automatic t_port(input logic b, input logic [11:0] da, dd);
    apb(1'h1, da, 8'h5A);
    settle;
    rdc("pin_rd", da, 32'hC3);
    apb(1'h1, dd, 8'hF0);
    settle;
    rdc("mix_rd", da, 32'h53);
    chk("oe", 32'hF0, {24'h0, b ? port_b_pin.oe : port_a_pin.oe});
    chk("out", 32'h50, {24'h0, 8'hF0 &
        (b ? port_b_pin.out : port_a_pin.out)});
  endtask

  // peripherals take their pins
  task automatic t_periph;
    apb(1'h1, `DPG_ADDR_DIRA, 8'hFF);
    chk("sink", 32'h30, {24'h0, port_b_high_sink});
    periph_sel <= {1'h1, 2'h1, 2'h0, 2'h0, 2'h1, `DPG_CONV_PIN7, 4'hF};
    serial_tx <= 1'h1;
    timer_out <= 4'h9;
    timer_out_en <= 4'h9;
    settle;
    chk("b_oe", 32'h75, {24'h0, port_b_pin.oe});
    chk("b_out", 32'h75, {24'h0, port_b_pin.out & port_b_pin.oe});
    chk("sink_p", 32'h11, {24'h0, port_b_high_sink});
    chk("analog", 32'h80, {24'h0, port_b_analog});
    chk("a_oe", 32'hF0, {24'h0, port_a_pin.oe});
    chk("rx", 32'h1, {31'h0, serial_rx});
    chk("keypad", 32'h3, {28'h0, keypad_in});
    chk("timer_in", 32'h9, {28'h0, timer_in});
    chk("a_analog", 32'h0, {24'h0, port_a_analog});
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end

  // main sequence
  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    periph_sel = '0;
    serial_tx = 1'h0;
    timer_out = 4'h0;
    timer_out_en = 4'h0;
    ext_a = 8'hC3;
    ext_b = 8'hC3;
    err_total = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs;
    t_port(1'h0, `DPG_ADDR_DATA_A, `DPG_ADDR_DIRA);
    t_port(1'h1, `DPG_ADDR_DATA_B, `DPG_ADDR_DIRB);
    t_periph;
    report_and_stop;
  end
endmodule
